// ===== design/flash_lock_cfg.svh
// Opcodes, status bit positions, geometry and timing constants
`ifndef FLASH_LOCK_CFG_SVH
`define FLASH_LOCK_CFG_SVH

`define CLK_PERIOD_NS 10
`define ADDR_BITS 23
`define SECTOR_LSB 12
`define SECTORS_PER_BLOCK 16

`define OP_NOP 8'h00
`define OP_LATCH_SET 8'h06
`define OP_PAGE_PROG 8'h02
`define OP_RESUME_A 8'h7a
`define OP_RESUME_B 8'h30
`define OP_RESET_ARM 8'h66
`define OP_LOCK_ONE 8'h36
`define OP_UNLOCK_ONE 8'h39
`define OP_LOCK_QUERY 8'h3c
`define OP_LOCK_ALL 8'h7e
`define OP_UNLOCK_ALL 8'h98

`define ST_BUSY_BIT 0
`define ST_LATCH_BIT 1
`define ST_ERASE_SUS_BIT 10
`define ST_PROG_SUS_BIT 15

`define PROG_TIME_NS 300000
`define ERASE_TIME_NS 2000000
`define PROG_SUSP_LAT_NS 20000
`define ERASE_SUSP_LAT_NS 20000

`endif

// ===== design/flash_lock_pkg.sv
// Types shared by the lock and resume logic
package flash_lock_pkg;
  typedef enum logic [1:0] {
    ACT_NONE = 2'b00,
    ACT_PROG = 2'b01,
    ACT_ERASE = 2'b10,
    ACT_NEST = 2'b11
  } act_e;
  typedef logic [15:0] status_t;
  typedef logic [23:0] addr_t;
endpackage : flash_lock_pkg

// ===== design/lock_bit_mem.sv
// One-bit-wide lock bit memory with registered read data
`timescale 1ns/1ps
module lock_bit_mem #(
  parameter int IDX_W = 11
) (
  // Clock
  input wire logic clk_sys_in,
  // Write port
  input wire logic wr_en_in,
  input wire logic [IDX_W-1:0] addr_in,
  input wire logic wr_data_in,
  // Read port
  input wire logic rd_en_in,
  output logic rd_data_out
);
  logic mem_r [0:(2**IDX_W)-1];

  always_ff @(posedge clk_sys_in) begin
    if (wr_en_in) begin
      mem_r[addr_in] <= wr_data_in;
    end
  end

  // No reset on read data: contents are filled by the walker after reset
  always_ff @(posedge clk_sys_in) begin
    if (rd_en_in) begin
      rd_data_out <= mem_r[addr_in];
    end
  end
endmodule : lock_bit_mem

// ===== design/flash_block_lock_and_resume.sv
// Command logic for erase-suspend programming, resume and block locks
`timescale 1ns/1ps
`include "flash_lock_cfg.svh"

module flash_block_lock_and_resume #(
  parameter int ADDR_W = `ADDR_BITS,
  parameter int PROG_CYCLES =
    (`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int ERASE_CYCLES =
    (`ERASE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int PROG_SUSP_CYCLES =
    (`PROG_SUSP_LAT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int ERASE_SUSP_CYCLES =
    (`ERASE_SUSP_LAT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter logic [7:0] SECT_ERASE_OP = 8'h20,
  parameter logic [7:0] BLOCK_ERASE_OP = 8'hd8,
  parameter logic [7:0] SUSPEND_OP = 8'h75
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Serial pins
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe_out,
  // Configuration
  input wire logic lock_scheme_select_in,
  input wire logic quad_command_mode_in,
  input wire logic lock_sector_grain_in,
  input wire logic range_protect_hit_in,
  // Status
  output logic write_enable_latch_out,
  output logic write_in_progress_out,
  output logic program_suspended_flag_out,
  output logic erase_suspended_flag_out,
  output logic reset_armed_out,
  output logic lock_walk_busy_out,
  output flash_lock_pkg::status_t status_reg_out,
  output flash_lock_pkg::addr_t cmd_addr_out
);
  import flash_lock_pkg::*;

  localparam int IDX_W = ADDR_W - `SECTOR_LSB;
  localparam int DEPTH = 2 ** IDX_W;

  generate
    if (ADDR_W < 17 || ADDR_W > 24) begin : g_bad_addr
      $error("ADDR_W must lie between 17 and 24");
    end
    if (PROG_CYCLES < 1 || ERASE_CYCLES < 1 || PROG_SUSP_CYCLES < 1 ||
        ERASE_SUSP_CYCLES < 1) begin : g_bad_time
      $error("timing counts must be at least one cycle");
    end
  endgenerate

  function automatic logic [IDX_W-1:0] sect_of(input logic [23:0] a);
    sect_of = a[ADDR_W-1:`SECTOR_LSB];
  endfunction : sect_of

  function automatic logic in_region(input logic [IDX_W-1:0] s,
                                     input logic [IDX_W-1:0] base,
                                     input logic blk);
    in_region = blk ? (s[IDX_W-1:4] == base[IDX_W-1:4]) : (s == base);
  endfunction : in_region

  // Pin synchronisers
  logic [1:0] cs_sync_r;
  logic [1:0] sclk_sync_r;
  logic [3:0] io_s1_r;
  logic [3:0] io_s2_r;
  logic cs_d_r;
  logic sclk_d_r;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cs_sync_r <= 2'h3;
      sclk_sync_r <= 2'h0;
      io_s1_r <= 4'h0;
      io_s2_r <= 4'h0;
      cs_d_r <= 1'b1;
      sclk_d_r <= 1'b0;
    end else begin
      cs_sync_r <= {cs_sync_r[0], cs_n_in};
      sclk_sync_r <= {sclk_sync_r[0], sclk_in};
      io_s1_r <= io_in;
      io_s2_r <= io_s1_r;
      cs_d_r <= cs_sync_r[1];
      sclk_d_r <= sclk_sync_r[1];
    end
  end

  logic cs_low;
  logic sclk_rise;
  logic sclk_fall;
  logic frame_end;
  assign cs_low = ~cs_sync_r[1];
  assign sclk_rise = sclk_sync_r[1] & ~sclk_d_r;
  assign sclk_fall = ~sclk_sync_r[1] & sclk_d_r;
  assign frame_end = cs_sync_r[1] & ~cs_d_r;

  // Input shifter
  logic [31:0] sh_r;
  logic [31:0] sh_nxt;
  logic [15:0] bits_r;
  logic [15:0] bits_nxt;
  logic [7:0] op_r;
  logic [23:0] addr_r;

  always_comb begin
    if (quad_command_mode_in) begin
      sh_nxt = {sh_r[27:0], io_s2_r};
      bits_nxt = bits_r + 16'h4;
    end else begin
      sh_nxt = {sh_r[30:0], io_s2_r[0]};
      bits_nxt = bits_r + 16'h1;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      sh_r <= 32'h0;
      bits_r <= 16'h0;
      op_r <= 8'h0;
      addr_r <= 24'h0;
    end else if (!cs_low) begin
      bits_r <= 16'h0;
    end else if (sclk_rise) begin
      sh_r <= sh_nxt;
      bits_r <= bits_nxt;
      if (bits_nxt == 16'h8) begin
        op_r <= sh_nxt[7:0];
      end
      if (bits_nxt == 16'h20) begin
        addr_r <= sh_nxt[23:0];
      end
    end
  end

  // Status and engine state
  logic latch_r;
  logic inprog_r;
  logic sus_prog_r;
  logic sus_erase_r;
  act_e act_r;
  act_e saved_act_r;
  logic [31:0] cnt_r;
  logic [31:0] saved_cnt_r;
  logic susp_wait_r;
  logic [31:0] susp_cnt_r;
  logic [IDX_W-1:0] erase_base_r;
  logic erase_blk_r;
  logic pend_r;
  act_e pend_kind_r;
  logic pend_blk_r;
  logic walk_busy_r;
  logic mem_rdata;

  // Command decode, valid only in the frame end cycle
  logic is_len8;
  logic is_len32;
  logic byte_ok;
  logic cmd_latch_set;
  logic cmd_pp;
  logic cmd_erase;
  logic cmd_susp;
  logic cmd_resume;
  logic cmd_lock_one;
  logic cmd_unlock_one;
  logic cmd_lock_all;
  logic cmd_unlock_all;
  logic idle;
  logic pp_ok;
  logic erase_ok;
  logic lock_start;
  logic chk_start;

  assign byte_ok = (bits_r[2:0] == 3'h0);
  assign is_len8 = frame_end & (bits_r == 16'h8);
  assign is_len32 = frame_end & (bits_r == 16'h20);
  assign cmd_latch_set = is_len8 & (op_r == `OP_LATCH_SET);
  assign cmd_pp = frame_end & byte_ok & (bits_r >= 16'h28) &
                  (op_r == `OP_PAGE_PROG);
  assign cmd_erase = is_len32 &
                     ((op_r == SECT_ERASE_OP) | (op_r == BLOCK_ERASE_OP));
  assign cmd_susp = is_len8 & (op_r == SUSPEND_OP);
  assign cmd_resume = is_len8 &
                      ((op_r == `OP_RESUME_A) | (op_r == `OP_RESUME_B));
  // Exact lengths double as the byte boundary check
  assign cmd_lock_one = is_len32 & (op_r == `OP_LOCK_ONE);
  assign cmd_unlock_one = is_len32 & (op_r == `OP_UNLOCK_ONE);
  assign cmd_lock_all = is_len8 & (op_r == `OP_LOCK_ALL);
  assign cmd_unlock_all = is_len8 & (op_r == `OP_UNLOCK_ALL);

  assign idle = ~inprog_r & ~walk_busy_r & ~pend_r & ~susp_wait_r &
                (act_r == ACT_NONE);
  assign pp_ok = cmd_pp & latch_r & idle & ~sus_prog_r &
                 (~sus_erase_r |
                  ~in_region(sect_of(addr_r), erase_base_r,
                             erase_blk_r));
  assign erase_ok = cmd_erase & latch_r & idle & ~sus_prog_r & ~sus_erase_r;
  assign chk_start = pp_ok | erase_ok;
  assign lock_start = latch_r & idle & (cmd_lock_one | cmd_unlock_one |
                      cmd_lock_all | cmd_unlock_all);

  // Protection verdict, one cycle after the lock bit read
  logic protected_hit;
  assign protected_hit = lock_scheme_select_in ?
                         (mem_rdata | walk_busy_r) :
                         range_protect_hit_in;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      pend_r <= 1'b0;
      pend_kind_r <= ACT_NONE;
      pend_blk_r <= 1'b0;
    end else begin
      pend_r <= chk_start;
      if (chk_start) begin
        pend_kind_r <= pp_ok ? (sus_erase_r ? ACT_NEST : ACT_PROG) :
                               ACT_ERASE;
        pend_blk_r <= (op_r == BLOCK_ERASE_OP);
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      latch_r <= 1'b0;
      inprog_r <= 1'b0;
      sus_prog_r <= 1'b0;
      sus_erase_r <= 1'b0;
      act_r <= ACT_NONE;
      saved_act_r <= ACT_NONE;
      cnt_r <= 32'h0;
      saved_cnt_r <= 32'h0;
      susp_wait_r <= 1'b0;
      susp_cnt_r <= 32'h0;
      erase_base_r <= '0;
      erase_blk_r <= 1'b0;
    end else if (pend_r) begin
      // A refused program or erase leaves every status bit as it was
      if (!protected_hit) begin
        act_r <= pend_kind_r;
        inprog_r <= 1'b1;
        cnt_r <= (pend_kind_r == ACT_ERASE) ? 32'(ERASE_CYCLES) :
                                              32'(PROG_CYCLES);
        if (pend_kind_r == ACT_ERASE) begin
          erase_base_r <= sect_of(addr_r);
          erase_blk_r <= pend_blk_r;
        end
      end
    end else if (cmd_latch_set && !inprog_r && !walk_busy_r) begin
      latch_r <= 1'b1;
    end else if (cmd_susp && !susp_wait_r &&
                 (act_r == ACT_PROG || act_r == ACT_ERASE)) begin
      // A nested program never matches here, so it cannot be suspended
      susp_wait_r <= 1'b1;
      susp_cnt_r <= (act_r == ACT_PROG) ? 32'(PROG_SUSP_CYCLES) :
                                          32'(ERASE_SUSP_CYCLES);
    end else if (cmd_resume && !inprog_r && (sus_prog_r || sus_erase_r)) begin
      latch_r <= 1'b1;
      inprog_r <= 1'b1;
      sus_prog_r <= 1'b0;
      sus_erase_r <= 1'b0;
      act_r <= saved_act_r;
      cnt_r <= saved_cnt_r;
    end else if (lock_start) begin
      latch_r <= 1'b0;
    end else if (act_r != ACT_NONE) begin
      cnt_r <= cnt_r - 32'h1;
      if (cnt_r == 32'h1) begin
        // Completion beats a pending suspend latency
        act_r <= ACT_NONE;
        latch_r <= 1'b0;
        inprog_r <= 1'b0;
        susp_wait_r <= 1'b0;
      end else if (susp_wait_r) begin
        susp_cnt_r <= susp_cnt_r - 32'h1;
        if (susp_cnt_r == 32'h1) begin
          susp_wait_r <= 1'b0;
          latch_r <= 1'b0;
          inprog_r <= 1'b0;
          sus_prog_r <= (act_r == ACT_PROG);
          sus_erase_r <= (act_r == ACT_ERASE);
          saved_act_r <= act_r;
          saved_cnt_r <= cnt_r - 32'h1;
          act_r <= ACT_NONE;
        end
      end
    end
  end

  // Reset arm tracking: any other complete command disarms it
  logic reset_arm_r;
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      reset_arm_r <= 1'b0;
    end else if (frame_end && bits_r >= 16'h8) begin
      reset_arm_r <= is_len8 & (op_r == `OP_RESET_ARM);
    end
  end

  // Lock bit walker; it also fills the memory after reset
  logic [IDX_W-1:0] walk_idx_r;
  logic [IDX_W:0] walk_left_r;
  logic walk_val_r;
  logic [IDX_W-1:0] addr_sect;
  assign addr_sect = sect_of(addr_r);

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      walk_busy_r <= 1'b1;
      walk_idx_r <= '0;
      walk_left_r <= (IDX_W+1)'(DEPTH);
      walk_val_r <= 1'b1;
    end else if (walk_busy_r) begin
      walk_idx_r <= walk_idx_r + 1'b1;
      walk_left_r <= walk_left_r - 1'b1;
      if (walk_left_r == (IDX_W+1)'(1)) begin
        walk_busy_r <= 1'b0;
      end
    end else if (lock_start) begin
      walk_busy_r <= 1'b1;
      walk_val_r <= cmd_lock_one | cmd_lock_all;
      if (cmd_lock_all || cmd_unlock_all) begin
        walk_idx_r <= '0;
        walk_left_r <= (IDX_W+1)'(DEPTH);
      end else if (lock_sector_grain_in) begin
        walk_idx_r <= sect_of(addr_r);
        walk_left_r <= (IDX_W+1)'(1);
      end else begin
        walk_idx_r <= {addr_sect[IDX_W-1:4], 4'h0};
        walk_left_r <= (IDX_W+1)'(`SECTORS_PER_BLOCK);
      end
    end
  end

  // Lock query read is issued as the last address bit lands
  logic stat_rd;
  logic stat_pend_r;
  logic [IDX_W-1:0] mem_addr;
  assign stat_rd = cs_low & sclk_rise & (bits_nxt == 16'h20) &
                   (op_r == `OP_LOCK_QUERY);
  assign mem_addr = walk_busy_r ? walk_idx_r :
                    (stat_rd ? sect_of(sh_nxt[23:0]) : sect_of(addr_r));

  lock_bit_mem #(
    .IDX_W(IDX_W)
  ) u_lock_mem (
    .clk_sys_in(clk_sys_in),
    .wr_en_in(walk_busy_r),
    .addr_in(mem_addr),
    .wr_data_in(walk_val_r),
    .rd_en_in(chk_start | stat_rd),
    .rd_data_out(mem_rdata)
  );

  // Lock query output byte, repeated while select stays low
  logic [7:0] out_byte_r;
  logic [2:0] oidx_r;
  logic [3:0] io_r;
  logic [3:0] io_oe_r;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      stat_pend_r <= 1'b0;
      out_byte_r <= 8'h0;
    end else begin
      stat_pend_r <= stat_rd;
      if (stat_pend_r) begin
        // Bits still being filled after reset read as locked
        out_byte_r <= {7'h0, mem_rdata | walk_busy_r};
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      io_r <= 4'h0;
      io_oe_r <= 4'h0;
      oidx_r <= 3'h0;
    end else if (!cs_low) begin
      io_oe_r <= 4'h0;
      oidx_r <= 3'h0;
    end else if (sclk_fall && op_r == `OP_LOCK_QUERY &&
                 bits_r >= 16'h20) begin
      oidx_r <= oidx_r + 3'h1;
      if (quad_command_mode_in) begin
        io_r <= oidx_r[0] ? out_byte_r[3:0] : out_byte_r[7:4];
        io_oe_r <= 4'hf;
      end else begin
        io_r <= {2'h0, out_byte_r[3'h7 - oidx_r], 1'b0};
        io_oe_r <= 4'h2;
      end
    end
  end

  // Registered status outputs
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      status_reg_out <= 16'h0;
      write_enable_latch_out <= 1'b0;
      write_in_progress_out <= 1'b0;
      program_suspended_flag_out <= 1'b0;
      erase_suspended_flag_out <= 1'b0;
      reset_armed_out <= 1'b0;
      lock_walk_busy_out <= 1'b1;
      cmd_addr_out <= 24'h0;
    end else begin
      status_reg_out <= 16'h0;
      status_reg_out[`ST_BUSY_BIT] <= inprog_r;
      status_reg_out[`ST_LATCH_BIT] <= latch_r;
      status_reg_out[`ST_ERASE_SUS_BIT] <= sus_erase_r;
      status_reg_out[`ST_PROG_SUS_BIT] <= sus_prog_r;
      write_enable_latch_out <= latch_r;
      write_in_progress_out <= inprog_r;
      program_suspended_flag_out <= sus_prog_r;
      erase_suspended_flag_out <= sus_erase_r;
      reset_armed_out <= reset_arm_r;
      lock_walk_busy_out <= walk_busy_r;
      cmd_addr_out <= addr_r;
    end
  end

  assign io_out = io_r;
  assign io_oe_out = io_oe_r;
endmodule : flash_block_lock_and_resume

// ===== testbench/flash_lock_monitor.sv
// Port-level checker for the lock and resume block
`timescale 1ns/1ps
module flash_lock_monitor (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Observed ports
  input wire logic cs_n_in,
  input wire logic [3:0] io_oe_out,
  input wire logic write_enable_latch_out,
  input wire logic write_in_progress_out,
  input wire logic program_suspended_flag_out,
  input wire logic erase_suspended_flag_out,
  input wire logic lock_walk_busy_out,
  input wire flash_lock_pkg::status_t status_reg_out
);
  import flash_lock_pkg::*;
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);
  a_status_layout: assert property (
    status_reg_out == {program_suspended_flag_out, 4'h0,
    erase_suspended_flag_out, 8'h00, write_enable_latch_out,
    write_in_progress_out}) else $error("status layout wrong");
  a_flags_exclusive: assert property (
    !(program_suspended_flag_out && erase_suspended_flag_out))
    else $error("both suspend flags set");
  a_suspend_quiet: assert property (
    $rose(erase_suspended_flag_out) || $rose(program_suspended_flag_out)
    |-> !write_in_progress_out && !write_enable_latch_out)
    else $error("suspend flag rose while busy");
  a_resume_sets: assert property (
    $fell(erase_suspended_flag_out) || $fell(program_suspended_flag_out)
    |-> write_in_progress_out && write_enable_latch_out)
    else $error("resume did not set latch and busy");
  a_nested_holds: assert property (
    erase_suspended_flag_out && $rose(write_in_progress_out) |->
    (write_in_progress_out && write_enable_latch_out)[*8])
    else $error("nested program dropped its bits");
  a_done_clears: assert property (
    $fell(write_in_progress_out) |-> !write_enable_latch_out)
    else $error("latch left set after busy fell");
  a_walk_after_reset: assert property (
    $fell(rst_in) |-> lock_walk_busy_out[*8])
    else $error("lock bits not refilled after reset");
  a_oe_idle: assert property (
    cs_n_in[*6] |-> io_oe_out == 4'h0)
    else $error("data lines driven while deselected");
  a_lock_clears_latch: assert property (
    $rose(lock_walk_busy_out) |-> !write_enable_latch_out)
    else $error("lock walk started with latch set");
  a_no_start_psus: assert property (
    $rose(write_in_progress_out) |-> !program_suspended_flag_out)
    else $error("operation started during program suspend");
  c_erase_susp: cover property ($rose(erase_suspended_flag_out));
  c_prog_resume: cover property ($fell(program_suspended_flag_out));
  c_lock_walk: cover property ($rose(lock_walk_busy_out));
endmodule : flash_lock_monitor

bind flash_block_lock_and_resume flash_lock_monitor u_mon (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .cs_n_in(cs_n_in),
  .io_oe_out(io_oe_out), .write_enable_latch_out(write_enable_latch_out),
  .write_in_progress_out(write_in_progress_out),
  .program_suspended_flag_out(program_suspended_flag_out),
  .erase_suspended_flag_out(erase_suspended_flag_out),
  .lock_walk_busy_out(lock_walk_busy_out),
  .status_reg_out(status_reg_out));

// ===== testbench/host_spi_model.sv
// Host serial controller model: frames, opcodes, address and read-back
`timescale 1ns/1ps
module host_spi_model (
  // Mode
  input wire logic quad_in,
  // Pins toward the device
  output logic cs_n_out,
  output logic sclk_out,
  output logic [3:0] io_drv_out,
  input wire logic [3:0] io_wire_in
);
  logic [7:0] rd_byte_r;
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    io_drv_out = 4'h0;
    rd_byte_r = 8'h00;
  end
  // Clock stands low between frames; data changes only while it is low
  task automatic frame(input logic [39:0] bits, input int nbits,
                       input int rd);
    cs_n_out = 1'b0;
    #62.5;
    for (int i = nbits; i > 0; i -= (quad_in ? 4 : 1)) begin
      // Upper lines toggle in single mode to show they are ignored
      io_drv_out = quad_in ? bits[i-1 -: 4] :
                   {~io_drv_out[3:1], bits[i-1]};
      #62.5 sclk_out = 1'b1;
      #62.5 sclk_out = 1'b0;
    end
    for (int k = 0; k < rd; k += (quad_in ? 4 : 1)) begin
      io_drv_out = ~io_drv_out;
      #62.5 sclk_out = 1'b1;
      rd_byte_r = quad_in ? {rd_byte_r[3:0], io_wire_in} :
                  {rd_byte_r[6:0], io_wire_in[1]};
      #62.5 sclk_out = 1'b0;
    end
    #62.5 cs_n_out = 1'b1;
    #100;
  endtask : frame
endmodule : host_spi_model

// ===== testbench/flash_block_lock_and_resume_tb.sv
// Self-checking bench for the lock and resume block
`timescale 1ns/1ps
`include "flash_lock_cfg.svh"
`define check(name, exp, got) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("mismatch %s expected %0h seen %0h", name, exp, got); \
  end \
end
module flash_block_lock_and_resume_tb;
  import flash_lock_pkg::*;
  logic clk_sys_in, rst_in, cs_n, sclk, quad, scheme, grain, range_hit;
  logic latch, inprog, psus, esus, armed, busy;
  logic [3:0] host_io, dev_io, io_oe, io_wire;
  status_t status;
  addr_t cmd_addr;
  int miscompares, tests_run;
  assign io_wire = (io_oe & dev_io) | (~io_oe & host_io);
  flash_block_lock_and_resume #(.PROG_CYCLES(200), .ERASE_CYCLES(400),
    .PROG_SUSP_CYCLES(20), .ERASE_SUSP_CYCLES(20)) DUT (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .cs_n_in(cs_n),
    .sclk_in(sclk), .io_in(io_wire), .io_out(dev_io), .io_oe_out(io_oe),
    .lock_scheme_select_in(scheme), .quad_command_mode_in(quad),
    .lock_sector_grain_in(grain), .range_protect_hit_in(range_hit),
    .write_enable_latch_out(latch), .write_in_progress_out(inprog),
    .program_suspended_flag_out(psus), .erase_suspended_flag_out(esus),
    .reset_armed_out(armed), .lock_walk_busy_out(busy),
    .status_reg_out(status), .cmd_addr_out(cmd_addr));
  host_spi_model u_host (.quad_in(quad), .cs_n_out(cs_n),
    .sclk_out(sclk), .io_drv_out(host_io), .io_wire_in(io_wire));
  always #5 clk_sys_in = ~clk_sys_in;
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run
  task automatic send(input logic [39:0] bits, input int nbits);
    u_host.frame(bits, nbits, 0);
    @(negedge clk_sys_in);
  endtask : send
  task automatic cmd(input logic [7:0] op);
    send({32'h0, op}, 8);
  endtask : cmd
  task automatic pp(input addr_t a);
    cmd(`OP_LATCH_SET);
    send({`OP_PAGE_PROG, a, 8'h5a}, 40);
  endtask : pp
  task automatic query(input addr_t a, input logic exp);
    u_host.frame({8'h00, `OP_LOCK_QUERY, a}, 32, 8);
    @(negedge clk_sys_in);
    `check("lock status", {7'h00, exp}, u_host.rd_byte_r)
  endtask : query
  // Polls wip, erase flag, walk busy or program flag, bounded
  task automatic wait_until(input int sel, input logic v, input int lim);
    logic s;
    for (int n = 0; n <= lim; n++) begin
      s = (sel == 0) ? inprog : (sel == 1) ? esus : (sel == 2) ? busy : psus;
      if (s === v) return;
      @(negedge clk_sys_in);
    end
    miscompares++;
    $display("mismatch wait %0d expected %0h seen %0h", sel, v, s);
    complete_run();
  endtask : wait_until
  initial begin
    clk_sys_in = 0; rst_in = 1; quad = 0; scheme = 1; grain = 0;
    range_hit = 0; miscompares = 0; tests_run = 0;
    repeat (4) @(negedge clk_sys_in);
    rst_in = 0;
    `check("status", 16'h0000, status)
    `check("walk busy", 1'b1, busy)
    query(24'h012345, 1'b1);
    wait_until(2, 1'b0, 3000);
    query(24'h7ff000, 1'b1);
    $display("reset test done");
    cmd(`OP_LATCH_SET);
    `check("latch", 1'b1, latch)
    cmd(`OP_UNLOCK_ALL);
    wait_until(2, 1'b0, 3000);
    query(24'h000000, 1'b0);
    query(24'h7ff000, 1'b0);
    quad = 1;
    cmd(`OP_LATCH_SET);
    cmd(`OP_LOCK_ALL);
    wait_until(2, 1'b0, 3000);
    query(24'h400000, 1'b1);
    quad = 0;
    cmd(`OP_LATCH_SET);
    cmd(`OP_UNLOCK_ALL);
    wait_until(2, 1'b0, 3000);
    cmd(`OP_LATCH_SET);
    send({28'h0, `OP_LOCK_ALL, 4'h0}, 12);
    `check("latch", 1'b1, latch)
    query(24'h400000, 1'b0);
    $display("global lock test done");
    cmd(`OP_LATCH_SET);
    send({8'h00, `OP_LOCK_ONE, 24'h130000}, 32);
    `check("address", 24'h130000, cmd_addr)
    wait_until(2, 1'b0, 100);
    query(24'h13f000, 1'b1);
    query(24'h120000, 1'b0);
    query(24'h140000, 1'b0);
    grain = 1;
    cmd(`OP_LATCH_SET);
    send({8'h00, `OP_UNLOCK_ONE, 24'h135000}, 32);
    wait_until(2, 1'b0, 100);
    query(24'h135000, 1'b0);
    query(24'h134000, 1'b1);
    $display("single lock test done");
    pp(24'h134000);
    `check("busy", 1'b0, inprog)
    pp(24'h135000);
    `check("busy", 1'b1, inprog)
    wait_until(0, 1'b0, 400);
    scheme = 0;
    range_hit = 1;
    pp(24'h134000);
    `check("busy", 1'b0, inprog)
    range_hit = 0;
    pp(24'h134000);
    `check("busy", 1'b1, inprog)
    wait_until(0, 1'b0, 400);
    `check("latch", 1'b0, latch)
    $display("protection test done");
    cmd(`OP_LATCH_SET);
    send({8'h00, DUT.SECT_ERASE_OP, 24'h200000}, 32);
    `check("busy", 1'b1, inprog)
    cmd(DUT.SUSPEND_OP);
    `check("erase flag", 1'b0, esus)
    `check("latch", 1'b1, latch)
    wait_until(1, 1'b1, 100);
    `check("status", 16'h0400, status)
    pp(24'h200100);
    `check("busy", 1'b0, inprog)
    pp(24'h300000);
    `check("status", 16'h0403, status)
    cmd(DUT.SUSPEND_OP);
    repeat (20) @(negedge clk_sys_in);
    `check("status", 16'h0403, status)
    wait_until(0, 1'b0, 400);
    `check("status", 16'h0400, status)
    cmd(`OP_RESUME_A);
    `check("status", 16'h0003, status)
    wait_until(0, 1'b0, 1000);
    `check("status", 16'h0000, status)
    $display("erase suspend test done");
    // Same block, other sector: only a block compare refuses it
    cmd(`OP_LATCH_SET);
    send({8'h00, DUT.BLOCK_ERASE_OP, 24'h200000}, 32);
    cmd(DUT.SUSPEND_OP);
    wait_until(1, 1'b1, 100);
    pp(24'h20f000);
    `check("busy", 1'b0, inprog)
    cmd(`OP_RESUME_A);
    wait_until(0, 1'b0, 1000);
    `check("status", 16'h0000, status)
    $display("block erase suspend test done");
    pp(24'h310000);
    cmd(DUT.SUSPEND_OP);
    wait_until(3, 1'b1, 100);
    `check("status", 16'h8000, status)
    cmd(`OP_RESUME_B);
    `check("status", 16'h0003, status)
    wait_until(0, 1'b0, 400);
    $display("program suspend test done");
    cmd(`OP_RESET_ARM);
    `check("armed", 1'b1, armed)
    cmd(`OP_NOP);
    `check("armed", 1'b0, armed)
    `check("status", 16'h0000, status)
    $display("no-operation test done");
    rst_in = 1;
    repeat (4) @(negedge clk_sys_in);
    rst_in = 0;
    `check("status", 16'h0000, status)
    wait_until(2, 1'b0, 3000);
    query(24'h000000, 1'b1);
    $display("mid-run reset test done");
    complete_run();
  end
endmodule : flash_block_lock_and_resume_tb
